// ### pkg/core_irq_pkg.sv
/*
 Constants for the core interrupt control block: APB register map,
 control register field positions, reset values and the vector address.
 Assumes a 32-bit APB bus with byte addresses and one word per register.
*/
// Behaviour
// - Global enable, bit 7, allows unmasked interrupts when set, blocks all when clear.
// - Any reset forces the global enable to zero.
// - Return-from-interrupt leaves the routine and sets the global enable.
// - Peripheral group enable, bit 6, gates all peripheral sources.
// - Accepting clears global enable, pushes return address, loads PC with 0004h.
// - Flags set on their condition regardless of any enable.
// - Clearing global enable blocks next-cycle interrupts and inserts a no-op.
// - Interrupts blocked that way stay pending until global enable returns.
// - Every source has its own enable; a clear enable prevents vectoring.
// - Timer-zero overflow sets flag bit 2; enable is bit 5.
// - External pin event sets flag bit 1; enable bit 4; reserved when absent.
// - Change on four upper port pins sets flag bit 0; enable bit 3.
// - All eight control bits read and write, reset to zero.
// - Single-peripheral build uses bit 6 directly as that source's enable.
// - More peripheral sources come as matched flag and enable register pairs.
// - Each peripheral source has its own enable, also gated by bit 6.
// - Each peripheral source has its own flag, set on its condition.
`default_nettype none
package core_irq_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTL = 8'h00;
	localparam logic [7:0] ADDR_PFLAG = 8'h04;
	localparam logic [7:0] ADDR_PEN = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;
	localparam logic [7:0] ADDR_STAT_CLR = 8'h10;
	localparam logic [7:0] ADDR_STAT_EN = 8'h14;
	localparam logic [7:0] ADDR_CPU = 8'h18;
	// Control register fields
	localparam int GLOBAL_EN_BIT = 7;
	localparam int GROUP_EN_BIT = 6;
	localparam int TIMER_EN_BIT = 5;
	localparam int EXTIE_BIT = 4;
	localparam int PCIE_BIT = 3;
	localparam int TIMER_FLAG_BIT = 2;
	localparam int EXTIF_BIT = 1;
	localparam int PCIF_BIT = 0;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] EXT_PIN_BITS = 8'h12;
	// Peripheral bank and port
	localparam int PERIPH_W = 8;
	localparam logic [7:0] PERIPH_RESET = 8'h00;
	localparam int PORT_W = 4;
	// Block status bits: taken, returned, no-op inserted
	localparam int STAT_W = 3;
	localparam int ST_TAKEN = 0;
	localparam int ST_RETURN = 1;
	localparam int ST_NOP = 2;
	localparam logic [2:0] STAT_RESET = 3'h0;
	// Program counter vector
	localparam int PC_W = 13;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam logic [12:0] PC_RESET = 13'h0000;
endpackage
`default_nettype wire

// ### hw/peripheral_flag_bank.sv
/*
 One matched pair of peripheral flag and peripheral enable registers.
 Assumes write strobes are single-cycle pulses from the bus slave and
 peripheral events are single-cycle pulses on the same clock.
*/
`default_nettype none
module peripheral_flag_bank
	import core_irq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic flag_wr,
	input wire logic enable_wr,
	input wire logic [PERIPH_W-1:0] wdata,
	input wire logic [PERIPH_W-1:0] event_set,
	output logic [PERIPH_W-1:0] flag_r,
	output logic [PERIPH_W-1:0] enable_r
);
	// Per-source flag and enable bits
	genvar i;
	generate
		for (i = 0; i < PERIPH_W; i++) begin : g_src
			// Hardware set wins over a software clear
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flag_r[i] <= PERIPH_RESET[i];
				end else if (event_set[i]) begin
					flag_r[i] <= 1'b1;
				end else if (flag_wr) begin
					flag_r[i] <= wdata[i];
				end
			end
			// Individual enable
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					enable_r[i] <= PERIPH_RESET[i];
				end else if (enable_wr) begin
					enable_r[i] <= wdata[i];
				end
			end
		end
	endgenerate
endmodule // peripheral_flag_bank
`default_nettype wire

// ### hw/core_interrupt_control.sv
/*
 Core interrupt control: control register with global, peripheral and
 core-source enables and flags, a peripheral flag/enable pair, the vector
 request to the CPU sequencer and an APB slave for all registers.
 Assumes the CPU sequencer pulses its instruction inputs for one cycle,
 and that event inputs are single-cycle pulses synchronous to pclk.
*/
`default_nettype none
module core_interrupt_control
	import core_irq_pkg::*;
#(
	parameter bit SINGLE_PERIPH = 1'b0,
	parameter bit EXT_PIN_PRESENT = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer_zero_ovf,
	input wire logic ext_pin_event,
	input wire logic [PORT_W-1:0] upper_port_pins,
	input wire logic [PERIPH_W-1:0] periph_event,
	input wire logic return_from_irq_instr,
	input wire logic global_clear_instr,
	output logic irq_request,
	output logic vector_take,
	output logic stack_push,
	output logic [PC_W-1:0] vector_pc,
	output logic nop_insert,
	output logic irq
);
	logic [7:0] ctl_r;
	logic [7:0] ctl_nxt;
	logic [7:0] ctl_mask;
	logic [PERIPH_W-1:0] pflag;
	logic [PERIPH_W-1:0] pen;
	logic [PORT_W-1:0] port_last_r;
	logic [PORT_W-1:0] port_diff;
	logic port_change;
	logic [STAT_W-1:0] stat_r;
	logic [STAT_W-1:0] stat_en_r;
	logic hold_r;
	logic core_hit;
	logic periph_hit;
	logic pending;
	logic take;
	logic global_clear_now;
	logic acc;
	logic wr;
	logic wr_ctl;

	// Bus decode for the access phase
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	assign wr_ctl = wr && (paddr == ADDR_CTL);

	// Reserved bits when the external pin is absent
	assign ctl_mask = EXT_PIN_PRESENT ? 8'hff : ~EXT_PIN_BITS;

	// Port change detect, one comparator per pin
	genvar g;
	generate
		for (g = 0; g < PORT_W; g++) begin : g_pin
			assign port_diff[g] = upper_port_pins[g] ^ port_last_r[g];
		end
	endgenerate
	assign port_change = |port_diff;

	// Last sampled port level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_last_r <= '0;
		end else begin
			port_last_r <= upper_port_pins;
		end
	end

	// Source qualification and request
	always_comb begin
		core_hit = (ctl_r[TIMER_EN_BIT] && ctl_r[TIMER_FLAG_BIT])
			|| (ctl_r[EXTIE_BIT] && ctl_r[EXTIF_BIT])
			|| (ctl_r[PCIE_BIT] && ctl_r[PCIF_BIT]);
		if (SINGLE_PERIPH) begin
			periph_hit = ctl_r[GROUP_EN_BIT] && pflag[0];
		end else begin
			periph_hit = ctl_r[GROUP_EN_BIT] && (|(pflag & pen));
		end
		pending = ctl_r[GLOBAL_EN_BIT] && (core_hit || periph_hit);
	end

	// Global enable being cleared this cycle blocks the next one
	assign global_clear_now = global_clear_instr
		|| (wr_ctl && !pwdata[GLOBAL_EN_BIT] && ctl_r[GLOBAL_EN_BIT]);
	assign take = pending && !hold_r && !global_clear_now;

	// Control register next value
	always_comb begin
		ctl_nxt = ctl_r;
		if (wr_ctl) begin
			ctl_nxt = pwdata[7:0];
		end
		if (timer_zero_ovf) begin
			ctl_nxt[TIMER_FLAG_BIT] = 1'b1;
		end
		if (ext_pin_event) begin
			ctl_nxt[EXTIF_BIT] = 1'b1;
		end
		if (port_change) begin
			ctl_nxt[PCIF_BIT] = 1'b1;
		end
		if (return_from_irq_instr) begin
			ctl_nxt[GLOBAL_EN_BIT] = 1'b1;
		end
		if (global_clear_instr || take) begin
			ctl_nxt[GLOBAL_EN_BIT] = 1'b0;
		end
		ctl_nxt = ctl_nxt & ctl_mask;
	end

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= CTL_RESET;
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	// One-cycle blocking window and no-op after a global clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_r <= 1'b0;
			nop_insert <= 1'b0;
		end else begin
			hold_r <= global_clear_now;
			nop_insert <= global_clear_now;
		end
	end

	// Vectoring outputs to the CPU sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_take <= 1'b0;
			stack_push <= 1'b0;
			vector_pc <= PC_RESET;
			irq_request <= 1'b0;
		end else begin
			vector_take <= take;
			stack_push <= take;
			irq_request <= pending;
			if (take) begin
				vector_pc <= IRQ_VECTOR;
			end
		end
	end

	// Peripheral flag and enable pair
	peripheral_flag_bank u_bank (
		.pclk(pclk),
		.presetn(presetn),
		.flag_wr(wr && (paddr == ADDR_PFLAG)),
		.enable_wr(wr && (paddr == ADDR_PEN)),
		.wdata(pwdata[PERIPH_W-1:0]),
		.event_set(periph_event),
		.flag_r(pflag),
		.enable_r(pen)
	);

	// Sticky block status, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= STAT_RESET;
		end else begin
			stat_r <= (stat_r & ~((wr && (paddr == ADDR_STAT_CLR)) ? pwdata[STAT_W-1:0] : '0))
				| {global_clear_now, return_from_irq_instr, take};
		end
	end

	// Status enable and interrupt line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_en_r <= STAT_RESET;
			irq <= 1'b0;
		end else begin
			if (wr && (paddr == ADDR_STAT_EN)) begin
				stat_en_r <= pwdata[STAT_W-1:0];
			end
			irq <= |(stat_r & stat_en_r);
		end
	end

	// APB answer: ready in the first access cycle, error on unmapped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= '0;
			case (paddr)
				ADDR_CTL: prdata[7:0] <= ctl_r;
				ADDR_PFLAG: prdata[PERIPH_W-1:0] <= pflag;
				ADDR_PEN: prdata[PERIPH_W-1:0] <= pen;
				ADDR_STAT: prdata[STAT_W-1:0] <= stat_r;
				ADDR_STAT_CLR: prdata <= '0;
				ADDR_STAT_EN: prdata[STAT_W-1:0] <= stat_en_r;
				ADDR_CPU: prdata[2:0] <= {hold_r, pending, ctl_r[GLOBAL_EN_BIT]};
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Checks
	sequence s_nop;
		nop_insert ##1 !vector_take;
	endsequence

	property p_take_clears_global;
		@(posedge pclk) disable iff (!presetn)
		vector_take |-> !ctl_r[GLOBAL_EN_BIT];
	endproperty
	a_take_clears_global: assert property (p_take_clears_global)
		else $error("global enable still set after vectoring");

	property p_take_vector;
		@(posedge pclk) disable iff (!presetn)
		vector_take |-> (stack_push && vector_pc == IRQ_VECTOR);
	endproperty
	a_take_vector: assert property (p_take_vector)
		else $error("vectoring without push or wrong vector");

	property p_take_needs_global;
		@(posedge pclk) disable iff (!presetn)
		vector_take |-> $past(ctl_r[GLOBAL_EN_BIT]);
	endproperty
	a_take_needs_global: assert property (p_take_needs_global)
		else $error("vectoring with global enable clear");

	property p_group_gates;
		@(posedge pclk) disable iff (!presetn)
		(vector_take && !$past(core_hit)) |-> $past(ctl_r[GROUP_EN_BIT]);
	endproperty
	a_group_gates: assert property (p_group_gates)
		else $error("peripheral vectoring with group enable clear");

	property p_masked;
		@(posedge pclk) disable iff (!presetn)
		vector_take |-> $past(core_hit || periph_hit);
	endproperty
	a_masked: assert property (p_masked)
		else $error("vectoring with no enabled flag");

	property p_return_sets;
		@(posedge pclk) disable iff (!presetn)
		(return_from_irq_instr && !global_clear_instr && !take) |=> ctl_r[GLOBAL_EN_BIT];
	endproperty
	a_return_sets: assert property (p_return_sets)
		else $error("return did not set global enable");

	property p_timer_flag;
		@(posedge pclk) disable iff (!presetn)
		timer_zero_ovf |=> ctl_r[TIMER_FLAG_BIT];
	endproperty
	a_timer_flag: assert property (p_timer_flag)
		else $error("timer overflow flag not set");

	property p_port_flag;
		@(posedge pclk) disable iff (!presetn)
		(upper_port_pins != port_last_r) |=> ctl_r[PCIF_BIT];
	endproperty
	a_port_flag: assert property (p_port_flag)
		else $error("port change flag not set");

	property p_nop_after_clear;
		@(posedge pclk) disable iff (!presetn)
		global_clear_now |=> s_nop;
	endproperty
	a_nop_after_clear: assert property (p_nop_after_clear)
		else $error("no-op missing or interrupt taken after clear");

	property p_nop_cause;
		@(posedge pclk) disable iff (!presetn)
		nop_insert |-> $past(global_clear_now);
	endproperty
	a_nop_cause: assert property (p_nop_cause)
		else $error("no-op inserted without a global clear");

	property p_flags_kept;
		@(posedge pclk) disable iff (!presetn)
		(global_clear_instr && !wr_ctl && ctl_r[EXTIF_BIT]) |=> ctl_r[EXTIF_BIT];
	endproperty
	a_flags_kept: assert property (p_flags_kept)
		else $error("pending flag lost on a global clear");

	property p_ext_flag;
		@(posedge pclk) disable iff (!presetn)
		(ext_pin_event && EXT_PIN_PRESENT) |=> ctl_r[EXTIF_BIT];
	endproperty
	a_ext_flag: assert property (p_ext_flag)
		else $error("external pin flag not set");

	property p_periph_flag;
		@(posedge pclk) disable iff (!presetn)
		(periph_event != '0) |=> ((pflag & $past(periph_event)) == $past(periph_event));
	endproperty
	a_periph_flag: assert property (p_periph_flag)
		else $error("peripheral flag not set on its event");

	property p_group_pair;
		@(posedge pclk) disable iff (!presetn)
		(vector_take && !$past(core_hit) && !SINGLE_PERIPH) |-> $past(|(pflag & pen));
	endproperty
	a_group_pair: assert property (p_group_pair)
		else $error("peripheral vectoring without an enabled flag pair");

	property p_request_needs_global;
		@(posedge pclk) disable iff (!presetn)
		irq_request |-> $past(ctl_r[GLOBAL_EN_BIT]);
	endproperty
	a_request_needs_global: assert property (p_request_needs_global)
		else $error("request raised with global enable clear");

	sequence s_single_take;
		vector_take ##1 !vector_take;
	endsequence

	property p_one_take;
		@(posedge pclk) disable iff (!presetn)
		take |=> s_single_take;
	endproperty
	a_one_take: assert property (p_one_take)
		else $error("vectoring pulse missing or repeated");

	property p_reset_clears_global;
		@(posedge pclk)
		!presetn |-> !ctl_r[GLOBAL_EN_BIT];
	endproperty
	a_reset_clears_global: assert property (p_reset_clears_global)
		else $error("global enable set during reset");
endmodule // core_interrupt_control
`default_nettype wire

// ### sim/cpu_seq_model.sv
/* CPU sequencer stand-in: turns bench commands into instruction pulses
 and counts accepted vectors. Assumes commands last one cycle. */
`default_nettype none
module cpu_seq_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic vector_take,
	input wire logic ret_cmd,
	input wire logic clr_cmd,
	output logic return_from_irq_instr,
	output logic global_clear_instr,
	output int takes
);
	timeunit 1ns;
	timeprecision 1ns;
	// Instruction pulses one cycle after each command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			return_from_irq_instr <= 1'b0;
			global_clear_instr <= 1'b0;
		end else begin
			return_from_irq_instr <= ret_cmd;
			global_clear_instr <= clr_cmd;
		end
	end
	// Vector acceptance count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			takes <= 0;
		end else if (vector_take) begin
			takes <= takes + 1;
		end
	end
endmodule // cpu_seq_model
`default_nettype wire

// ### sim/test_core_interrupt_control.sv
/* Self-checking bench: APB tasks, event pulses, CPU model.
 Assumes the APB slave answers within a few cycles. */
`default_nettype none
module test_core_interrupt_control
	import core_irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic timer_zero_ovf, ext_pin_event, ret_cmd, clr_cmd;
	logic return_from_irq_instr, global_clear_instr;
	logic irq_request, vector_take, stack_push, nop_insert, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [PORT_W-1:0] upper_port_pins;
	logic [PERIPH_W-1:0] periph_event;
	logic [PC_W-1:0] vector_pc;
	int takes, failures, checks_done, t0;
	core_interrupt_control i_core_interrupt_control (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_zero_ovf(timer_zero_ovf),
		.ext_pin_event(ext_pin_event), .upper_port_pins(upper_port_pins),
		.periph_event(periph_event), .return_from_irq_instr(return_from_irq_instr),
		.global_clear_instr(global_clear_instr), .irq_request(irq_request),
		.vector_take(vector_take), .stack_push(stack_push), .vector_pc(vector_pc),
		.nop_insert(nop_insert), .irq(irq));
	cpu_seq_model i_cpu_seq_model (.pclk(pclk), .presetn(presetn), .vector_take(vector_take),
		.ret_cmd(ret_cmd), .clr_cmd(clr_cmd), .return_from_irq_instr(return_from_irq_instr),
		.global_clear_instr(global_clear_instr), .takes(takes));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic finish_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer, then one idle edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			failures++;
			finish_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
		chk({31'h0, e}, {31'h0, err});
	endtask
	// Bounded wait for a vector (nop=0) or an inserted no-op (nop=1)
	task automatic wait_for(input bit nop);
		int n;
		for (n = 0; n < 10; n++) begin
			@(negedge pclk);
			if ((nop ? nop_insert : vector_take) === 1'b1) break;
		end
		if (n == 10) begin
			failures++;
			finish_test();
		end
		if (!nop) begin
			chk({19'h0, vector_pc}, {19'h0, IRQ_VECTOR});
			chk({31'h0, stack_push}, 32'h1);
			chk({31'h0, irq_request}, 32'h1);
		end
		@(posedge pclk);
	endtask
	task automatic chk_irq(input logic exp);
		@(negedge pclk);
		chk({31'h0, irq}, {31'h0, exp});
		@(posedge pclk);
	endtask
	task automatic ret_pulse();
		ret_cmd <= 1'b1;
		@(posedge pclk);
		ret_cmd <= 1'b0;
	endtask
	// Reset values, read-write bits, unmapped address
	task automatic t_reset();
		rd(ADDR_CTL, 32'h0, 1'b0);
		apb(1'b1, ADDR_CTL, 32'h7f);
		rd(ADDR_CTL, 32'h7f, 1'b0);
		chk(takes, 0);
		apb(1'b1, ADDR_CTL, 32'h0);
		rd(8'h1c, 32'h0, 1'b1);
	endtask
	// Flags set with every enable off
	task automatic t_poll();
		timer_zero_ovf <= 1'b1;
		ext_pin_event <= 1'b1;
		upper_port_pins <= 4'h8;
		@(posedge pclk);
		timer_zero_ovf <= 1'b0;
		ext_pin_event <= 1'b0;
		rd(ADDR_CTL, 32'h07, 1'b0);
		apb(1'b1, ADDR_CTL, 32'h0);
		rd(ADDR_CTL, 32'h0, 1'b0);
	endtask
	// Timer vector, status interrupt, flag clear, return
	task automatic t_vector();
		apb(1'b1, ADDR_STAT_EN, 32'h1);
		apb(1'b1, ADDR_CTL, 32'ha0);
		timer_zero_ovf <= 1'b1;
		@(posedge pclk);
		timer_zero_ovf <= 1'b0;
		wait_for(1'b0);
		rd(ADDR_CTL, 32'h24, 1'b0);
		chk_irq(1'b1);
		apb(1'b1, ADDR_STAT_EN, 32'h0);
		chk_irq(1'b0);
		apb(1'b1, ADDR_STAT_EN, 32'h1);
		chk_irq(1'b1);
		apb(1'b1, ADDR_STAT_CLR, 32'h7);
		chk_irq(1'b0);
		apb(1'b1, ADDR_CTL, 32'h20);
		t0 = takes;
		ret_pulse();
		repeat (4) @(posedge pclk);
		rd(ADDR_CTL, 32'ha0, 1'b0);
		rd(ADDR_CPU, 32'h1, 1'b0);
		chk(takes, t0);
	endtask
	// Peripheral source gated by its group enable
	task automatic t_periph();
		apb(1'b1, ADDR_PEN, 32'h1);
		apb(1'b1, ADDR_CTL, 32'h80);
		t0 = takes;
		periph_event <= 8'h01;
		timer_zero_ovf <= 1'b1;
		@(posedge pclk);
		periph_event <= 8'h00;
		timer_zero_ovf <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(takes, t0);
		rd(ADDR_PFLAG, 32'h1, 1'b0);
		apb(1'b1, ADDR_CTL, 32'hc0);
		wait_for(1'b0);
		apb(1'b1, ADDR_PFLAG, 32'h0);
		apb(1'b1, ADDR_CTL, 32'h0);
	endtask
	// Global clear blocks the next cycle, request stays pending
	task automatic t_hold();
		apb(1'b1, ADDR_CTL, 32'h90);
		t0 = takes;
		clr_cmd <= 1'b1;
		ext_pin_event <= 1'b1;
		@(posedge pclk);
		clr_cmd <= 1'b0;
		ext_pin_event <= 1'b0;
		wait_for(1'b1);
		chk(takes, t0);
		rd(ADDR_CTL, 32'h12, 1'b0);
		ret_pulse();
		wait_for(1'b0);
		rd(ADDR_STAT, 32'h7, 1'b0);
		apb(1'b1, ADDR_STAT_CLR, 32'h7);
		rd(ADDR_STAT, 32'h0, 1'b0);
	endtask
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, timer_zero_ovf, ext_pin_event, ret_cmd} = '0;
		clr_cmd = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		upper_port_pins = 4'h0;
		periph_event = 8'h00;
		failures = 0;
		checks_done = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({31'h0, irq_request}, 32'h0);
		t_reset();
		t_poll();
		t_vector();
		t_periph();
		t_hold();
		finish_test();
	end
endmodule // test_core_interrupt_control
`default_nettype wire
